// *** rtl/irq_controller.sv ***
/*
 * interrupt controller with AHB-Lite registers and core redirect sequence;
 * assumes a single clock, q1 strobe from the core, synchronous events.
 */
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "irq_ctrl_regs.svh"
module irq_controller #(
    parameter int NREG = 7
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // events
    input wire logic [NREG*8-1:0] periph_event,
    input wire logic ext_event,
    // core side
    input wire logic q1_strobe,
    input wire logic retfi_exec,
    output irq_ctrl_pkg::core_cmd_t core_cmd,
    output logic irq_out
);
    initial begin
        if (NREG != 7) $error("seven flag registers required");
    end

    // ============================================================
    // register state
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] flag_r [NREG], flag_nxt [NREG];
    logic [7:0] en_r [NREG], en_nxt [NREG];
    logic [1:0] cstat_r, cstat_nxt, cmask_r, cmask_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [11:0] wa_r, wa_nxt;
    logic [31:0] hrdata_nxt;
    logic irq_out_nxt;
    irq_ctrl_pkg::seq_state_t st_r, st_nxt;
    irq_ctrl_pkg::core_cmd_t cmd_nxt;
    logic [NREG*8-1:0] flags_flat, en_flat;
    logic request;

    function automatic logic in_range(input logic [11:0] a,
                                      input logic [11:0] base);
        in_range = (a >= base) && (a < base + 12'(NREG * 4));
    endfunction

    function automatic int idx_of(input logic [11:0] a,
                                  input logic [11:0] base);
        idx_of = int'((a - base) >> 2);
    endfunction

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            flags_flat[i*8 +: 8] = flag_r[i];
            en_flat[i*8 +: 8] = en_r[i];
        end
    end

    irq_combine #(.NREG(NREG)) u_comb (
        .flags(flags_flat),
        .enables(en_flat),
        .ext_flag(ctrl_r[`EXT_FLAG_BIT]),
        .ext_enable(ctrl_r[`EXT_ENABLE_BIT]),
        .group_enable(ctrl_r[`PGIE_BIT]),
        .global_enable(ctrl_r[`GLOBAL_EN_BIT]),
        .request(request)
    );

    // ============================================================
    // bus and registers
    logic addr_ok, wr_take, accept, ret_take;
    logic [31:0] rd_val;
    always_comb begin
        addr_ok = hsel & hready & htrans[1];
        // latency follows where the core puts its q1 strobe
        accept = (st_r == irq_ctrl_pkg::ST_IDLE) & q1_strobe & request; // [RL11] [RL12]
        ret_take = (st_r == irq_ctrl_pkg::ST_IDLE) & retfi_exec & ~accept;
        wr_take = wr_pend_r;
        ctrl_nxt = ctrl_r;
        cstat_nxt = cstat_r;
        cmask_nxt = cmask_r;
        for (int i = 0; i < NREG; i++) begin
            flag_nxt[i] = flag_r[i];
            en_nxt[i] = en_r[i];
        end
        // software writes first, hardware sets override
        if (wr_take) begin
            if (wa_r == `IRQ_CONTROL_OFF) ctrl_nxt = hwdata[7:0];
            else if (wa_r == `CORE_IRQ_STAT_OFF)
                cstat_nxt = cstat_r & ~hwdata[1:0];
            else if (wa_r == `CORE_IRQ_MASK_OFF) cmask_nxt = hwdata[1:0];
            else if (in_range(wa_r, `FLAG_BASE_OFF))
                flag_nxt[idx_of(wa_r, `FLAG_BASE_OFF)] = hwdata[7:0]; // [RL13]
            else if (in_range(wa_r, `ENABLE_BASE_OFF))
                en_nxt[idx_of(wa_r, `ENABLE_BASE_OFF)] = hwdata[7:0];
        end
        for (int i = 0; i < NREG; i++)
            flag_nxt[i] = flag_nxt[i] | periph_event[i*8 +: 8]; // [RL3] [RL4]
        if (ext_event) ctrl_nxt[`EXT_FLAG_BIT] = 1'b1; // [RL3]
        if (accept) begin
            ctrl_nxt[`GLOBAL_EN_BIT] = 1'b0; // [RL5]
            cstat_nxt[0] = 1'b1;
        end
        if (ret_take) begin
            ctrl_nxt[`GLOBAL_EN_BIT] = 1'b1; // [RL10]
            cstat_nxt[1] = 1'b1;
        end
        rd_val = 32'h0000_0000;
        if (haddr == `IRQ_CONTROL_OFF) rd_val[7:0] = ctrl_r;
        else if (haddr == `CORE_IRQ_STAT_OFF) rd_val[1:0] = cstat_r;
        else if (haddr == `CORE_IRQ_MASK_OFF) rd_val[1:0] = cmask_r;
        else if (in_range(haddr, `FLAG_BASE_OFF))
            rd_val[7:0] = flag_r[idx_of(haddr, `FLAG_BASE_OFF)];
        else if (in_range(haddr, `ENABLE_BASE_OFF))
            rd_val[7:0] = en_r[idx_of(haddr, `ENABLE_BASE_OFF)];
        hrdata_nxt = (addr_ok & ~hwrite) ? rd_val : hrdata;
        wr_pend_nxt = addr_ok & hwrite;
        wa_nxt = (addr_ok & hwrite) ? haddr : wa_r;
        irq_out_nxt = |(cstat_nxt & cmask_nxt);
    end

    // ============================================================
    // redirect sequence
    always_comb begin
        st_nxt = st_r;
        cmd_nxt = '0;
        case (st_r)
            irq_ctrl_pkg::ST_IDLE: begin
                if (accept) begin
                    st_nxt = irq_ctrl_pkg::ST_FLUSH;
                    cmd_nxt.flush = 1'b1; // [RL5]
                end else if (ret_take) begin
                    st_nxt = irq_ctrl_pkg::ST_RETURN;
                    cmd_nxt.pop = 1'b1; // [RL10]
                    cmd_nxt.restore = 1'b1; // [RL10]
                end
            end
            irq_ctrl_pkg::ST_FLUSH: begin
                st_nxt = irq_ctrl_pkg::ST_PUSH;
                cmd_nxt.push = 1'b1; // [RL6]
            end
            irq_ctrl_pkg::ST_PUSH: begin
                st_nxt = irq_ctrl_pkg::ST_SAVE;
                cmd_nxt.save = 1'b1; // [RL7]
            end
            irq_ctrl_pkg::ST_SAVE: begin
                st_nxt = irq_ctrl_pkg::ST_VECTOR;
                cmd_nxt.load_pc = 1'b1; // [RL8]
                cmd_nxt.pc_value = `IRQ_VECTOR; // [RL8]
            end
            irq_ctrl_pkg::ST_VECTOR: st_nxt = irq_ctrl_pkg::ST_IDLE;
            irq_ctrl_pkg::ST_RETURN: st_nxt = irq_ctrl_pkg::ST_IDLE;
            default: st_nxt = irq_ctrl_pkg::ST_IDLE;
        endcase
    end

    // ============================================================
    // control, flag and enable registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CONTROL_RST; // [RL1]
            for (int i = 0; i < NREG; i++) begin
                flag_r[i] <= `FLAG_RST;
                en_r[i] <= `ENABLE_RST; // [RL1]
            end
            cstat_r <= 2'h0;
            cmask_r <= 2'h0;
        end else if (clk_en) begin
            ctrl_r <= ctrl_nxt;
            for (int i = 0; i < NREG; i++) begin
                flag_r[i] <= flag_nxt[i];
                en_r[i] <= en_nxt[i];
            end
            cstat_r <= cstat_nxt;
            cmask_r <= cmask_nxt;
        end
    end

    // ============================================================
    // bus side registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wa_r <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend_r <= wr_pend_nxt;
            wa_r <= wa_nxt;
            hrdata <= hrdata_nxt;
            // zero wait states, always okay
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ============================================================
    // sequencer and interrupt output registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= irq_ctrl_pkg::ST_IDLE;
            core_cmd <= '0;
            irq_out <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            core_cmd <= cmd_nxt;
            irq_out <= irq_out_nxt;
        end
    end

    // ============================================================
    // cycles away from idle, for the bounded sequence check
    logic [2:0] busy_cnt_r, busy_cnt_nxt;
    always_comb begin
        busy_cnt_nxt = busy_cnt_r;
        if (st_r == irq_ctrl_pkg::ST_IDLE) busy_cnt_nxt = 3'h0;
        else if (busy_cnt_r != 3'h7) busy_cnt_nxt = busy_cnt_r + 3'h1;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) busy_cnt_r <= 3'h0;
        else if (clk_en) busy_cnt_r <= busy_cnt_nxt;
    end

    // ============================================================
    // checks
    sequence s_redirect;
        core_cmd.flush ##1 core_cmd.push ##1 core_cmd.save
            ##1 (core_cmd.load_pc && core_cmd.pc_value == `IRQ_VECTOR);
    endsequence

    sequence s_return;
        core_cmd.pop && core_cmd.restore && !core_cmd.flush;
    endsequence

    // redirect steps
    chk_accept_flush: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && accept) |=> core_cmd.flush && !ctrl_r[`GLOBAL_EN_BIT]) // [RL5]
        else $error("accept did not flush and clear global enable");
    chk_vector_seq: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && accept) |=> s_redirect) // [RL6] [RL7]
        else $error("vector sequence broken");
    chk_seq_order: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(core_cmd.flush) && clk_en) |-> s_redirect) // [RL8]
        else $error("redirect steps out of order");
    chk_flush_global_low: assert property (@(posedge clock) disable iff (!rst_n)
        core_cmd.flush |-> !ctrl_r[`GLOBAL_EN_BIT]) // [RL5]
        else $error("global enable still set at flush");
    chk_push_follows: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && core_cmd.flush) |=> core_cmd.push) // [RL6]
        else $error("push did not follow flush");
    chk_save_follows: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && core_cmd.push) |=> core_cmd.save) // [RL7]
        else $error("save did not follow push");
    chk_push_save: assert property (@(posedge clock) disable iff (!rst_n)
        core_cmd.push |-> !core_cmd.save && !core_cmd.load_pc) // [RL6] [RL7]
        else $error("push overlapped later steps");
    chk_vector_value: assert property (@(posedge clock) disable iff (!rst_n)
        core_cmd.load_pc |-> core_cmd.pc_value == `IRQ_VECTOR) // [RL8]
        else $error("wrong vector address");
    chk_vector_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        !core_cmd.load_pc |-> core_cmd.pc_value == 15'h0000) // [RL8]
        else $error("pc value shown without load");
    chk_load_then_idle: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && core_cmd.load_pc) |=> st_r == irq_ctrl_pkg::ST_IDLE) // [RL8]
        else $error("sequencer not idle after vector");
    chk_no_flush_busy: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && st_r != irq_ctrl_pkg::ST_IDLE) |=> !core_cmd.flush) // [RL5]
        else $error("second flush inside a redirect");
    chk_seq_bounded: assert property (@(posedge clock) disable iff (!rst_n)
        busy_cnt_r <= 3'h4) // [RL8]
        else $error("redirect sequence too long");

    // gating and sampling
    chk_no_global_redirect: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && !ctrl_r[`GLOBAL_EN_BIT]) |=> !core_cmd.flush) // [RL9]
        else $error("redirect with global enable clear");
    chk_q1_only: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(core_cmd.flush) |-> $past(q1_strobe)) // [RL11]
        else $error("request sampled outside q1");
    chk_group_gate: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && q1_strobe && st_r == irq_ctrl_pkg::ST_IDLE
            && !ctrl_r[`PGIE_BIT]
            && !(ctrl_r[`EXT_FLAG_BIT] && ctrl_r[`EXT_ENABLE_BIT]))
        |=> !core_cmd.flush) // [RL2]
        else $error("peripheral source passed a closed group gate");
    chk_reset_clear: assert property (@(posedge clock)
        !rst_n |=> !ctrl_r[`GLOBAL_EN_BIT] && st_r == irq_ctrl_pkg::ST_IDLE) // [RL1]
        else $error("reset left interrupts enabled");

    // flags
    chk_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && periph_event[0]) |=> flag_r[0][0]) // [RL3]
        else $error("event flag not set");
    chk_ext_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && ext_event) |=> ctrl_r[`EXT_FLAG_BIT]) // [RL3]
        else $error("external flag not set");
    chk_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && !wr_pend_r && flag_r[0][0]) |=> flag_r[0][0]) // [RL4]
        else $error("flag dropped without a write");

    // return
    chk_return_gie: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && ret_take) |=> ctrl_r[`GLOBAL_EN_BIT] && core_cmd.pop) // [RL10]
        else $error("return did not pop and set global enable");
    chk_return_pair: assert property (@(posedge clock) disable iff (!rst_n)
        core_cmd.pop |-> s_return) // [RL10]
        else $error("pop without restore");

    // status, interrupt output and bus
    chk_stat_accept: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && accept) |=> cstat_r[0])
        else $error("accept status not set");
    chk_stat_return: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && ret_take) |=> cstat_r[1])
        else $error("return status not set");
    chk_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
        irq_out == |(cstat_r & cmask_r))
        else $error("interrupt output disagrees with status and mask");
    chk_freeze: assert property (@(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(st_r) && $stable(core_cmd))
        else $error("state moved while clock enable low");
    chk_bus_okay: assert property (@(posedge clock) disable iff (!rst_n)
        hreadyout && !hresp)
        else $error("bus response not ready and okay");
endmodule // irq_controller

// *** shared/irq_ctrl_regs.svh ***
/*
 * register offsets, field positions, reset values and timing counts of the
 * interrupt controller; assumes 32-bit AHB-Lite word registers.
 */
// Behaviour
// [RL1] every reset leaves all interrupt enables cleared so nothing vectors.
// [RL2] a source vectors only with global enable, its own enable, and for peripheral sources the group enable.
// [RL3] a flag is set by its event whatever the state of any enable bit.
// [RL4] peripheral flags live in seven flag registers, one bit per source.
// [RL5] accepting an interrupt flushes the prefetched instruction and clears the global enable.
// [RL6] accepting an interrupt pushes the current program counter onto the return stack.
// [RL7] accepting an interrupt copies the critical core registers into shadow registers.
// [RL8] after flush, push and save the program counter is loaded with vector 0004h.
// [RL9] with global enable clear events still set flags but never redirect the core.
// [RL10] the return-from-interrupt instruction pops the stack, restores context and sets global enable.
// [RL11] pending requests are sampled only in the first quarter-phase of an instruction cycle.
// [RL12] latency from event to vector depends on the instruction that is executing.
// [RL13] the service routine clears each serviced flag before returning, or it is taken again.
// [RL14] the request is the OR of flag AND enable, group-gated for peripherals, then global-gated.
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// byte offsets
`define IRQ_CONTROL_OFF 12'h000
`define FLAG_BASE_OFF 12'h004
`define ENABLE_BASE_OFF 12'h020
`define CORE_IRQ_STAT_OFF 12'h03c
`define CORE_IRQ_MASK_OFF 12'h040

// fields of the control register
`define GLOBAL_EN_BIT 7
`define PGIE_BIT 6
`define EXT_FLAG_BIT 0
`define EXT_ENABLE_BIT 4

// reset values
`define CONTROL_RST 8'h00
`define FLAG_RST 8'h00
`define ENABLE_RST 8'h00

// vector and timing
`define IRQ_VECTOR 15'h0004
`define Q_PHASES 4

`endif

// *** shared/irq_ctrl_pkg.sv ***
/*
 * types of the interrupt controller; assumes the core drives the
 * quarter-phase strobe and the return instruction decode.
 */
package irq_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FLUSH = 3'b001,
        ST_PUSH = 3'b010,
        ST_SAVE = 3'b011,
        ST_VECTOR = 3'b100,
        ST_RETURN = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic flush;
        logic push;
        logic save;
        logic load_pc;
        logic pop;
        logic restore;
        logic [14:0] pc_value;
    } core_cmd_t;

endpackage

// *** rtl/irq_combine.sv ***
/*
 * combines flags and enables into the single interrupt request;
 * assumes inputs are registered in the caller.
 */
`timescale 1ns/10ps
module irq_combine #(
    parameter int NREG = 7
) (
    // flags and enables
    input wire logic [NREG*8-1:0] flags,
    input wire logic [NREG*8-1:0] enables,
    input wire logic ext_flag,
    input wire logic ext_enable,
    // gates
    input wire logic group_enable,
    input wire logic global_enable,
    // result
    output logic request
);
    always_comb begin
        // flag and enable, group gated for peripherals, then global gated
        request = global_enable & ((ext_flag & ext_enable) |
            (group_enable & |(flags & enables))); // [RL14] [RL2] [RL9]
    end
endmodule // irq_combine

// *** sim/core_model.sv ***
/*
 * core partner: quarter-phase strobe, return instruction, pc and stack.
 * assumes core_cmd pulses from the interrupt controller, one clock.
 */
`timescale 1ns/10ps
module core_model #(
    parameter int QDIV = 4,
    parameter logic [14:0] HOME = 15'h0123
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // controller side
    input irq_ctrl_pkg::core_cmd_t core_cmd,
    output logic q1_strobe,
    output logic retfi_exec,
    // bench side
    input wire logic ret_req,
    output logic [14:0] pc
);
    int ph;
    logic [14:0] stk[$];
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 0;
            q1_strobe <= 1'b0;
            retfi_exec <= 1'b0;
            pc <= HOME;
        end else begin
            ph <= (ph == QDIV - 1) ? 0 : ph + 1;
            q1_strobe <= (ph == QDIV - 1);
            retfi_exec <= ret_req;
            if (core_cmd.push) stk.push_back(pc);
            if (core_cmd.load_pc) pc <= core_cmd.pc_value;
            if (core_cmd.pop && stk.size() > 0) pc <= stk.pop_back();
        end
    end
endmodule // core_model

// *** sim/tb_top.sv ***
/*
 * self-checking bench of the interrupt controller.
 * assumes core_model as the core and the register header on the path.
 */
`timescale 1ns/10ps
`include "irq_ctrl_regs.svh"
module tb_top;
    localparam logic [14:0] HOME = 15'h0123;
    logic clock, rst_n, hsel, hwrite, hready, hreadyout, hresp, ext_event;
    logic q1_strobe, retfi_exec, irq_out, ret_req;
    logic [11:0] haddr, fa, ea;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [55:0] periph_event;
    logic [14:0] pc;
    irq_ctrl_pkg::core_cmd_t core_cmd;
    int miscompares = 0, n_checks = 0, cyc = 0, seed = 15, i, b;
    assign hready = hreadyout;
    irq_controller u_irq_controller (.clock(clock), .rst_n(rst_n),
        .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .periph_event(periph_event), .ext_event(ext_event),
        .q1_strobe(q1_strobe), .retfi_exec(retfi_exec),
        .core_cmd(core_cmd), .irq_out(irq_out));
    core_model #(.HOME(HOME)) u_core_model (.clock(clock), .rst_n(rst_n),
        .core_cmd(core_cmd), .q1_strobe(q1_strobe),
        .retfi_exec(retfi_exec), .ret_req(ret_req), .pc(pc));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (!hready);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (!hready);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask
    task automatic cmd6(input logic [5:0] exp);
        chk({26'h0, core_cmd[20:15]}, {26'h0, exp});
    endtask
    // wait for the flush, then one step of the redirect each cycle
    task automatic accept;
        int n;
        n = 0;
        @(negedge clock);
        while (!core_cmd.flush && n < 40) begin
            n++;
            @(negedge clock);
        end
        cmd6(6'b100000);
        @(negedge clock);
        cmd6(6'b010000);
        @(negedge clock);
        cmd6(6'b001000);
        @(negedge clock);
        cmd6(6'b000100);
        chk({17'h0, core_cmd.pc_value}, {17'h0, `IRQ_VECTOR});
        @(posedge clock);
    endtask
    task automatic quiet(input int n);
        logic f;
        f = 1'b0;
        repeat (n) begin
            @(negedge clock);
            f = f | core_cmd.flush;
        end
        chk({31'h0, f}, 32'h0);
        @(posedge clock);
    endtask
    task automatic ret;
        int n;
        n = 0;
        ret_req <= 1'b1;
        @(posedge clock);
        ret_req <= 1'b0;
        @(negedge clock);
        while (!core_cmd.pop && n < 8) begin
            n++;
            @(negedge clock);
        end
        cmd6(6'b000011);
        @(negedge clock);
        @(posedge clock);
    endtask
    task automatic irqc(input logic exp);
        repeat (3) @(negedge clock);
        chk({31'h0, irq_out}, {31'h0, exp});
        @(posedge clock);
    endtask
    initial begin
        rst_n = 1'b0;
        {hsel, hwrite, ext_event, ret_req} = 4'h0;
        {haddr, htrans, hwdata, periph_event} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rdc(`IRQ_CONTROL_OFF, 32'h0);
        for (i = 0; i < 7; i++) begin
            rdc(`FLAG_BASE_OFF + 12'(i * 4), 32'h0);
            rdc(`ENABLE_BASE_OFF + 12'(i * 4), 32'h0);
        end
        rdc(12'h100, 32'h0);
        repeat (4) begin
            i = {$random(seed)} % 7;
            b = {$random(seed)} % 8;
            fa = `FLAG_BASE_OFF + 12'(i * 4);
            ea = `ENABLE_BASE_OFF + 12'(i * 4);
            wr(ea, 32'(1 << b));
            wr(`IRQ_CONTROL_OFF, 32'h80);
            periph_event <= 56'(1) << (i * 8 + b);
            @(posedge clock);
            periph_event <= '0;
            rdc(fa, 32'(1 << b));
            quiet(12);
            wr(`IRQ_CONTROL_OFF, 32'hc0);
            accept();
            rdc(`IRQ_CONTROL_OFF, 32'h40);
            quiet(12);
            wr(fa, 32'h0);
            ret();
            chk({17'h0, pc}, {17'h0, HOME});
            rdc(`IRQ_CONTROL_OFF, 32'hc0);
            quiet(12);
            wr(ea, 32'h0);
        end
        wr(`IRQ_CONTROL_OFF, 32'h90);
        ext_event <= 1'b1;
        @(posedge clock);
        ext_event <= 1'b0;
        accept();
        rdc(`IRQ_CONTROL_OFF, 32'h11);
        wr(`IRQ_CONTROL_OFF, 32'h10);
        ret();
        rdc(`CORE_IRQ_STAT_OFF, 32'h3);
        irqc(1'b0);
        wr(`CORE_IRQ_MASK_OFF, 32'h1);
        irqc(1'b1);
        wr(`CORE_IRQ_STAT_OFF, 32'h1);
        irqc(1'b0);
        rdc(`CORE_IRQ_STAT_OFF, 32'h2);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        rdc(`IRQ_CONTROL_OFF, 32'h0);
        conclude();
    end
endmodule // tb_top
